// >>> core/sec_rx_pkg.sv
// Constants shared by the secondary receive slot map and its deserialiser.
package sec_rx_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int NUM_CHANS = 3;
  localparam logic [7:0] PIN_SEL_ADDR = 8'h27;
  localparam logic [7:0] PIN_SEL_RESET = 8'h00;
  localparam logic [7:0] CHAN_ADDR [NUM_CHANS] = '{8'h28, 8'h29, 8'h2A};
  localparam logic [7:0] CHAN_RESET [NUM_CHANS] = '{8'h00, 8'h01, 8'h02};
  localparam logic [7:0] READ_NONE = 8'h00;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int ENABLE_BIT = 5;
  localparam int SLOT_MSB = 4;
  localparam int SLOT_BITS = 5;
  localparam logic [1:0] RSVD_ZERO = 2'h0;
  localparam logic [4:0] PIN_SEL_PAD = 5'h00;

  // ---------------------------------------------------------------------------
  // Frame formats and framing
  // ---------------------------------------------------------------------------
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ = 2'h2;
  localparam int WORD_BITS = 32;
  localparam int POS_BITS = 10;
  localparam logic [4:0] LAST_BIT = 5'h1F;
  localparam logic [9:0] POS_STEP = 10'h001;
  localparam logic [4:0] SLOT_STEP = 5'h01;

endpackage

// >>> core/slot_deserializer.sv
// Serial-to-word deserialiser that tags each received word with its slot code.
module slot_deserializer (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Synchronised link samples, valid on each bit clock rising edge.
  input wire logic sample_en,
  input wire logic frame_sync,
  input wire logic data_bit,
  // Frame format.
  input wire logic [1:0] audio_format,
  // Received words.
  output logic [31:0] word,
  output logic [4:0] word_slot,
  output logic word_valid
);

  // ---------------------------------------------------------------------------
  // Framing decode
  // ---------------------------------------------------------------------------
  logic fs_d1;
  logic fs_d2;
  logic in_frame;
  logic [9:0] bit_pos;
  logic [30:0] shift;

  // I2S data lags the frame sync by one bit, so its edges are seen one sample late.
  wire is_i2s = (audio_format == sec_rx_pkg::FMT_I2S);
  wire is_lj = (audio_format == sec_rx_pkg::FMT_LJ);
  wire is_tdm = !is_i2s && !is_lj;
  wire eff_fs = is_i2s ? fs_d1 : frame_sync;
  wire eff_prev = is_i2s ? fs_d2 : fs_d1;
  wire boundary = is_tdm ? (eff_fs & ~eff_prev) : (eff_fs ^ eff_prev);
  wire right_half = is_i2s ? eff_fs : ~eff_fs;
  wire [9:0] cur_pos = boundary ? '0 : bit_pos;
  wire last_bit = (cur_pos[4:0] == sec_rx_pkg::LAST_BIT);
  wire in_range = is_tdm || !cur_pos[9];
  wire [4:0] slot_code = is_tdm ? cur_pos[9:5] : {right_half, cur_pos[8:5]};
  wire word_done = sample_en && (in_frame || boundary) && last_bit && in_range;

  // Shift in one bit per bit clock and track the position within the frame.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fs_d1 <= 1'b0;
      fs_d2 <= 1'b0;
      in_frame <= 1'b0;
      bit_pos <= '0;
      shift <= '0;
    end else if (sample_en) begin
      fs_d1 <= frame_sync;
      fs_d2 <= fs_d1;
      in_frame <= in_frame | boundary;
      bit_pos <= sec_rx_pkg::POS_BITS'(cur_pos + sec_rx_pkg::POS_STEP);
      shift <= {shift[29:0], data_bit};
    end
  end

  // Present each completed word with its slot code for one cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word <= '0;
      word_slot <= '0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= word_done;
      if (word_done) begin
        word <= {shift, data_bit};
        word_slot <= slot_code;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [4:0] tdm_words;

  // Steps the word count, wrapping at the 32 slots of a frame.
  function automatic logic [4:0] slot_step_up(input logic [4:0] v);
    slot_step_up = v + sec_rx_pkg::SLOT_STEP;
  endfunction

  // Counts words since the last frame start, for the slot check.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tdm_words <= '0;
    end else if (sample_en && boundary) begin
      tdm_words <= '0;
    end else if (word_valid) begin
      tdm_words <= slot_step_up(tdm_words);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  tdm_slot_count_a: assert property (word_valid && is_tdm |-> word_slot == tdm_words)
    else $error("TDM slot code does not match word position.");
  lj_half_a: assert property (word_valid && is_lj |-> word_slot[4] == !$past(frame_sync))
    else $error("Left-justified half does not match frame sync.");
  i2s_half_a: assert property (word_valid && is_i2s |-> word_slot[4] == $past(fs_d1))
    else $error("I2S half does not match delayed frame sync.");
  right_slot_c: cover property (word_valid && !is_tdm && word_slot[4]);

endmodule

// >>> core/sec_rx_slot_map.sv
// Secondary serial receive port: channel 1 to 3 enables, slot map and pin select.
module sec_rx_slot_map (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Register access port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Frame format: TDM, I2S or left-justified.
  input wire logic [1:0] audio_format,
  // Serial link pins driven by the audio host.
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic serial_data_in,
  input wire logic serial_data_in_second,
  // DAC channel samples.
  output logic [31:0] dac_chan1_data,
  output logic dac_chan1_valid,
  output logic [31:0] dac_chan2_data,
  output logic dac_chan2_valid,
  output logic [31:0] dac_chan3_data,
  output logic dac_chan3_valid
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic bclk_prev;

  // Every link pin passes two flip-flops; only the second stage is read.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      bclk_prev <= 1'b0;
    end else begin
      pin_meta <= {bit_clk, frame_sync, serial_data_in, serial_data_in_second};
      pin_sync <= pin_meta;
      bclk_prev <= pin_sync[3];
    end
  end

  // The host launches data on the falling edge, so it is taken on the rising one.
  wire bclk_rise = pin_sync[3] & ~bclk_prev;
  wire fs_sync = pin_sync[2];
  wire din_first_sync = pin_sync[1];
  wire din_second_sync = pin_sync[0];

  // ---------------------------------------------------------------------------
  // Deserialisers, one per data pin
  // ---------------------------------------------------------------------------
  logic [31:0] word_first;
  logic [31:0] word_second;
  logic [4:0] word_slot;
  logic word_valid;

  // Both pins share bit clock and frame sync, so the first one supplies timing.
  slot_deserializer u_deser_first (
    .core_clk(core_clk),
    .rstn(rstn),
    .sample_en(bclk_rise),
    .frame_sync(fs_sync),
    .data_bit(din_first_sync),
    .audio_format(audio_format),
    .word(word_first),
    .word_slot(word_slot),
    .word_valid(word_valid)
  );

  slot_deserializer u_deser_second (
    .core_clk(core_clk),
    .rstn(rstn),
    .sample_en(bclk_rise),
    .frame_sync(fs_sync),
    .data_bit(din_second_sync),
    .audio_format(audio_format),
    .word(word_second),
    .word_slot(),
    .word_valid()
  );

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  logic [2:0] pin_select;
  logic chan_enable [sec_rx_pkg::NUM_CHANS];
  logic [4:0] chan_slot [sec_rx_pkg::NUM_CHANS];
  logic wr_chan [sec_rx_pkg::NUM_CHANS];
  logic hit [sec_rx_pkg::NUM_CHANS];
  logic [31:0] pick_word [sec_rx_pkg::NUM_CHANS];
  logic [31:0] dac_data [sec_rx_pkg::NUM_CHANS];
  logic dac_valid [sec_rx_pkg::NUM_CHANS];
  logic [7:0] next_rdata;

  // Builds a channel configuration byte; the reserved top bits always read zero.
  function automatic logic [7:0] cfg_byte(input logic en, input logic [4:0] slot);
    cfg_byte = {sec_rx_pkg::RSVD_ZERO, en, slot};
  endfunction

  wire wr_pin = reg_write && (reg_addr == sec_rx_pkg::PIN_SEL_ADDR);

  // Read selection by address; unmapped addresses read zero.
  assign next_rdata = (reg_addr == sec_rx_pkg::CHAN_ADDR[0]) ? cfg_byte(chan_enable[0], chan_slot[0]) :
                      (reg_addr == sec_rx_pkg::CHAN_ADDR[1]) ? cfg_byte(chan_enable[1], chan_slot[1]) :
                      (reg_addr == sec_rx_pkg::CHAN_ADDR[2]) ? cfg_byte(chan_enable[2], chan_slot[2]) :
                      (reg_addr == sec_rx_pkg::PIN_SEL_ADDR) ? {sec_rx_pkg::PIN_SEL_PAD, pin_select} :
                      sec_rx_pkg::READ_NONE;

  // Read data is registered, so it answers one cycle after the address.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= sec_rx_pkg::READ_NONE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Pin select bits for channels 1 to 3; higher channels are not built.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_select <= sec_rx_pkg::PIN_SEL_RESET[2:0];
    end else if (wr_pin) begin
      pin_select <= reg_wdata[2:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Channel configuration and routing
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < sec_rx_pkg::NUM_CHANS; c++) begin : g_chan
    // Write strobe, slot match and pin choice for this channel.
    assign wr_chan[c] = reg_write && (reg_addr == sec_rx_pkg::CHAN_ADDR[c]);
    assign hit[c] = chan_enable[c] && word_valid && (word_slot == chan_slot[c]);
    assign pick_word[c] = pin_select[c] ? word_second : word_first;

    // Enable and slot fields; writes to the reserved bits are dropped.
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chan_enable[c] <= sec_rx_pkg::CHAN_RESET[c][sec_rx_pkg::ENABLE_BIT];
        chan_slot[c] <= sec_rx_pkg::CHAN_RESET[c][sec_rx_pkg::SLOT_MSB:0];
      end else if (wr_chan[c]) begin
        chan_enable[c] <= reg_wdata[sec_rx_pkg::ENABLE_BIT];
        chan_slot[c] <= reg_wdata[sec_rx_pkg::SLOT_MSB:0];
      end
    end

    // The sample register loads only on a matching slot of an enabled channel.
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        dac_data[c] <= '0;
        dac_valid[c] <= 1'b0;
      end else begin
        dac_valid[c] <= hit[c];
        if (hit[c]) begin
          dac_data[c] <= pick_word[c];
        end
      end
    end
  end

  // Sample outputs, straight from the per-channel registers.
  assign dac_chan1_data = dac_data[0];
  assign dac_chan1_valid = dac_valid[0];
  assign dac_chan2_data = dac_data[1];
  assign dac_chan2_valid = dac_valid[1];
  assign dac_chan3_data = dac_data[2];
  assign dac_chan3_valid = dac_valid[2];

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic cfg_written;

  // Remembers whether software has written anything since reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_written <= 1'b0;
    end else if (reg_write) begin
      cfg_written <= 1'b1;
    end
  end

  wire chan_addr_hit = (reg_addr == sec_rx_pkg::CHAN_ADDR[0]) || (reg_addr == sec_rx_pkg::CHAN_ADDR[1]) ||
                       (reg_addr == sec_rx_pkg::CHAN_ADDR[2]);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  ch1_off_a: assert property (!chan_enable[0] |=> !dac_chan1_valid)
    else $error("Disabled channel 1 produced a sample.");
  ch1_route_a: assert property (chan_enable[0] && word_valid && word_slot == chan_slot[0]
                                |=> dac_chan1_valid && dac_chan1_data == $past(pick_word[0]))
    else $error("Channel 1 missed its slot word.");
  ch2_gate_a: assert property (dac_chan2_valid |-> $past(chan_enable[1]) && $past(word_slot) == $past(chan_slot[1]))
    else $error("Channel 2 sample without enable or slot match.");
  ch3_gate_a: assert property (dac_chan3_valid |-> $past(chan_enable[2]) && $past(word_slot) == $past(chan_slot[2]))
    else $error("Channel 3 sample without enable or slot match.");
  rsvd_read_a: assert property (chan_addr_hit |=> reg_rdata[7:6] == sec_rx_pkg::RSVD_ZERO)
    else $error("Reserved bits read nonzero.");
  ch1_reset_a: assert property (!cfg_written && reg_addr == sec_rx_pkg::CHAN_ADDR[0]
                                |=> reg_rdata == sec_rx_pkg::CHAN_RESET[0])
    else $error("Channel 1 config not at reset value.");
  ch2_reset_a: assert property (!cfg_written && reg_addr == sec_rx_pkg::CHAN_ADDR[1]
                                |=> reg_rdata == sec_rx_pkg::CHAN_RESET[1])
    else $error("Channel 2 config not at reset value.");
  ch3_reset_a: assert property (!cfg_written && reg_addr == sec_rx_pkg::CHAN_ADDR[2]
                                |=> reg_rdata == sec_rx_pkg::CHAN_RESET[2])
    else $error("Channel 3 config not at reset value.");
  pin_pick_a: assert property (dac_chan1_valid |-> dac_chan1_data == ($past(pin_select[0]) ?
                               $past(word_second) : $past(word_first)))
    else $error("Channel 1 took data from the wrong pin.");

  ch1_sample_c: cover property (dac_chan1_valid);
  ch2_second_pin_c: cover property (dac_chan2_valid && pin_select[1]);
  ch3_sample_c: cover property (dac_chan3_valid);

endmodule

// >>> tb/audio_host_model.sv
// Behavioural audio host that drives frames onto the secondary link pins.
module audio_host_model (
  // Link pins toward the receive port.
  output logic bit_clk,
  output logic frame_sync,
  output logic data_a,
  output logic data_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------------------
  // Idle levels
  // --------------------------------------------------------------------------
  // The bit clock stands still low between frames.
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    data_a = 1'b0;
    data_b = 1'b1;
  end

  // --------------------------------------------------------------------------
  // Frame generation
  // --------------------------------------------------------------------------
  // Drives one bit, then gives it a full 320 ns bit period, rising edge mid-bit.
  task automatic put_bit(input logic fs, input logic da, input logic db);
    frame_sync = fs;
    data_a = da;
    data_b = db;
    #160 bit_clk = 1'b1;
    #160 bit_clk = 1'b0;
  endtask

  // Sends slots 0 to nslots-1 of each half, MSB first; word index is the slot code.
  task automatic send_frame(input logic [1:0] fmt, input int nslots, input logic [31:0] wa [32],
                            input logic [31:0] wb [32]);
    int halves;
    logic lj;
    logic fs;
    lj = (fmt == sec_rx_pkg::FMT_LJ);
    halves = (lj || fmt == sec_rx_pkg::FMT_I2S) ? 2 : 1;
    // Odd offset keeps the link unrelated in phase to the core clock.
    #13;
    // Two lead bits give I2S its falling edge one bit before the MSB.
    put_bit(fmt == sec_rx_pkg::FMT_I2S, ~data_a, ~data_b);
    put_bit(1'b0, ~data_a, ~data_b);
    for (int h = 0; h < halves; h++) begin
      for (int s = 0; s < nslots; s++) begin
        for (int b = 31; b >= 0; b--) begin
          fs = (halves == 1) ? (s == 0 && b == 31) : lj ? (h == 0) : (h == 1 || (s == nslots - 1 && b == 0));
          put_bit(fs, wa[16 * h + s][b], wb[16 * h + s][b]);
        end
      end
    end
    // Released data lines show the inverse of their last level.
    data_a = ~data_a;
    data_b = ~data_b;
  endtask
endmodule

// >>> tb/sec_rx_slot_map_test.sv
// Self-checking bench for the secondary receive slot map.
module sec_rx_slot_map_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] audio_format = 2'h0;
  logic bit_clk;
  logic frame_sync;
  logic data_a;
  logic data_b;
  logic [31:0] dac_data [3];
  logic [2:0] dac_valid;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] exp_q [3][$];
  logic [31:0] wa [32];
  logic [31:0] wb [32];
  logic [4:0] slot [3];
  logic [2:0] en;
  logic [2:0] pin_sel;
  logic tdm;
  int nslots;
  logic [1:0] fmt_tab [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  logic [4:0] slot_tab [5] = '{5'h1F, 5'h1F, 5'h10, 5'h0F, 5'h00};

  sec_rx_slot_map sec_rx_slot_map_i (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .audio_format(audio_format),
    .bit_clk(bit_clk), .frame_sync(frame_sync), .serial_data_in(data_a), .serial_data_in_second(data_b),
    .dac_chan1_data(dac_data[0]), .dac_chan1_valid(dac_valid[0]), .dac_chan2_data(dac_data[1]),
    .dac_chan2_valid(dac_valid[1]), .dac_chan3_data(dac_data[2]), .dac_chan3_valid(dac_valid[2]));
  audio_host_model audio_host_model_i (.bit_clk(bit_clk), .frame_sync(frame_sync), .data_a(data_a),
    .data_b(data_b));

  // --------------------------------------------------------------------------
  // Clock, timeout and reporting
  // --------------------------------------------------------------------------
  // The 25 MHz core clock.
  always #20 core_clk = ~core_clk;

  // Cuts a hang short well above the longest expected run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Compares one register read.
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one DAC sample or count.
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  // One-cycle write strobe; the next call lets an edge pass before raising it.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // Read data is registered one cycle after the address is sampled.
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 check_reg(reg_rdata, exp);
  endtask

  // --------------------------------------------------------------------------
  // Sample monitor
  // --------------------------------------------------------------------------
  // Every valid pulse takes the oldest note of its channel; no note means a stray sample.
  always @(posedge core_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (dac_valid[c] === 1'b1) begin
        if (exp_q[c].size() == 0) begin
          check_word(dac_data[c], 'x);
        end else begin
          check_word(dac_data[c], exp_q[c].pop_front());
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(13));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    reg_rd(sec_rx_pkg::PIN_SEL_ADDR, sec_rx_pkg::PIN_SEL_RESET);
    for (int c = 0; c < 3; c++) begin
      reg_rd(sec_rx_pkg::CHAN_ADDR[c], sec_rx_pkg::CHAN_RESET[c]);
    end
    // Unmapped writes vanish and reserved bits never stick.
    reg_wr(8'h2B, 8'hFF);
    reg_rd(8'h2B, sec_rx_pkg::READ_NONE);
    for (int c = 0; c < 3; c++) begin
      reg_wr(sec_rx_pkg::CHAN_ADDR[c], 8'hFF);
      reg_rd(sec_rx_pkg::CHAN_ADDR[c], 8'h3F);
    end
    // Each frame maps random slots, enables and pins, with boundary slots on channel 1, which is enabled in all frames but the fourth.
    for (int f = 0; f < 5; f++) begin
      tdm = !(fmt_tab[f] == sec_rx_pkg::FMT_I2S || fmt_tab[f] == sec_rx_pkg::FMT_LJ);
      pin_sel = 3'($urandom());
      nslots = 1;
      for (int i = 0; i < 32; i++) begin
        wa[i] = $urandom();
        wb[i] = $urandom();
      end
      for (int c = 0; c < 3; c++) begin
        slot[c] = (c == 0) ? slot_tab[f] : 5'($urandom());
        en[c] = (c == 0) ? (f != 3) : 1'($urandom());
        nslots = tdm ? ((slot[c] >= nslots) ? slot[c] + 1 : nslots) : ((slot[c][3:0] >= nslots) ? slot[c][3:0] + 1 : nslots);
        reg_wr(sec_rx_pkg::CHAN_ADDR[c], {2'h0, en[c], slot[c]});
        reg_rd(sec_rx_pkg::CHAN_ADDR[c], {2'h0, en[c], slot[c]});
        if (en[c]) begin
          exp_q[c].push_back(pin_sel[c] ? wb[slot[c]] : wa[slot[c]]);
        end
      end
      reg_wr(sec_rx_pkg::PIN_SEL_ADDR, {5'h00, pin_sel});
      reg_rd(sec_rx_pkg::PIN_SEL_ADDR, {5'h00, pin_sel});
      @(posedge core_clk);
      audio_format <= fmt_tab[f];
      audio_host_model_i.send_frame(fmt_tab[f], nslots, wa, wb);
      repeat (20) @(posedge core_clk);
    end
    for (int c = 0; c < 3; c++) begin
      check_word(32'(exp_q[c].size()), 32'h0);
    end
    stop_test();
  end
endmodule
